// *** design/rpc_top.sv ***
// Reference clock select, PLL divider, charge pump and calibration control.
// Assumes an APB master on the system clock; the PLL lock comes as a level
// from the analog macro, synchronous to the system clock.
`timescale 1ns/1ps
module rpc_top #(
  parameter int VCO_CAL_CYC = rpc_pkg::VCO_CAL_CYC,
  parameter int LOCK_CYC    = rpc_pkg::LOCK_CYC
) (
  input  wire logic        CLK_SYS,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        PLL_LOCK_RAW,
  output logic             PLL_SEL,
  output logic      [8:0]  PLL_MULT,
  output logic      [10:0] CHARGE_PUMP_CURRENT,
  output logic             VCO_CAL_ACTIVE,
  output logic             DAC_CAL,
  output logic             IRQ
);
  logic [31:0] general_config_register;
  logic [31:0] pll_config_register;
  logic [31:0] dac_config_register;
  logic [rpc_pkg::IRQ_W-1:0] irq_st_reg;
  logic [rpc_pkg::IRQ_W-1:0] irq_en_reg;
  logic [rpc_pkg::IRQ_W-1:0] irq_set;
  logic [rpc_pkg::IRQ_W-1:0] irq_clr;
  logic        wr;
  logic        rd;
  logic        vco_bit_q_reg;
  logic        cal_start;
  logic        cal_busy;
  logic        cal_done;
  logic        lock_busy;
  logic        lock_done;
  logic        locked_reg;
  logic        locked_q_reg;
  logic [2:0]  auto_cp_reg;
  logic [2:0]  cp_code;
  logic [7:0]  div;
  logic        pll_en;
  logic        mapped;

  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && PENABLE && !PWRITE;
  assign div = pll_config_register[rpc_pkg::DIV_LSB +: 8];
  assign pll_en = pll_config_register[rpc_pkg::BIT_PLL_EN];
  assign mapped = PADDR == rpc_pkg::OFF_GENERAL || PADDR == rpc_pkg::OFF_PLL
    || PADDR == rpc_pkg::OFF_DAC || PADDR == rpc_pkg::OFF_LOCK
    || PADDR == rpc_pkg::OFF_IRQ_ST || PADDR == rpc_pkg::OFF_IRQ_EN
    || PADDR == rpc_pkg::OFF_IRQ_CLR || PADDR == rpc_pkg::OFF_MULT;

  // Config registers; divider below minimum is kept as written by software
  // Writes land at the edge that completes the access, with PREADY high
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      general_config_register <= 32'h0000_0000;
      pll_config_register <= {16'h0000, rpc_pkg::DIV_RESET, 1'b0, 1'b0,
        rpc_pkg::CP_RESET, 3'h0};                                    // [R7]
      dac_config_register <= 32'h0000_0000;
      irq_en_reg <= '0;
    end
    else if (wr && PREADY)
    begin
      if (PADDR == rpc_pkg::OFF_GENERAL)
        general_config_register <= PWDATA;
      if (PADDR == rpc_pkg::OFF_PLL)
        pll_config_register <= PWDATA;
      if (PADDR == rpc_pkg::OFF_DAC)
        dac_config_register <= PWDATA;                               // [R12]
      if (PADDR == rpc_pkg::OFF_IRQ_EN)
        irq_en_reg <= PWDATA[rpc_pkg::IRQ_W-1:0];
    end
  end

  // One wait state: PREADY rises in the second access cycle
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end
    else if (PSEL && PENABLE && !PREADY)
    begin
      PREADY  <= 1'b1;
      PSLVERR <= !mapped;
      PRDATA  <= 32'h0000_0000;
      if (rd)
      begin
        case (PADDR)
          rpc_pkg::OFF_GENERAL: PRDATA <= general_config_register;
          rpc_pkg::OFF_PLL:     PRDATA <= pll_config_register;
          rpc_pkg::OFF_DAC:     PRDATA <= dac_config_register;
          rpc_pkg::OFF_LOCK:
            PRDATA <= 32'(locked_reg) << rpc_pkg::BIT_LOCK;          // [R11]
          rpc_pkg::OFF_IRQ_ST:  PRDATA <= 32'(irq_st_reg);
          rpc_pkg::OFF_IRQ_EN:  PRDATA <= 32'(irq_en_reg);
          rpc_pkg::OFF_MULT:    PRDATA <= {23'h00_0000, div, 1'b0};
          default:              PRDATA <= 32'h0000_0000;
        endcase
      end
    end
    else
    begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // Rising edge of the calibration bit starts the sequence while the PLL is enabled
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      vco_bit_q_reg <= 1'b0;
    else
      vco_bit_q_reg <= general_config_register[rpc_pkg::BIT_VCO_CAL];
  end
  assign cal_start = general_config_register[rpc_pkg::BIT_VCO_CAL]
    && !vco_bit_q_reg && pll_en;                                     // [R13]

  rpc_timer #(.CYC(VCO_CAL_CYC)) u_cal (
    .clk   (CLK_SYS),
    .rst   (SYS_RST),
    .start (cal_start),
    .abort (!pll_en),
    .busy  (cal_busy),
    .done  (cal_done)
  );

  rpc_timer #(.CYC(LOCK_CYC)) u_lock (
    .clk   (CLK_SYS),
    .rst   (SYS_RST),
    .start (cal_done),
    .abort (!pll_en || cal_start),
    .busy  (lock_busy),
    .done  (lock_done)
  );

  // Automatic current choice from the divider band, latched at cal start
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      auto_cp_reg <= rpc_pkg::CP_RESET;
    else if (cal_start)                                              // [R6]
    begin
      if (div < 8'd16)       auto_cp_reg <= 3'h0;
      else if (div < 8'd24)  auto_cp_reg <= 3'h1;
      else if (div < 8'd36)  auto_cp_reg <= 3'h2;
      else if (div < 8'd44)  auto_cp_reg <= 3'h3;
      else if (div < 8'd56)  auto_cp_reg <= 3'h4;
      else if (div < 8'd64)  auto_cp_reg <= 3'h5;
      else if (div < 8'd80)  auto_cp_reg <= 3'h6;
      else                   auto_cp_reg <= 3'h7;
    end
  end
  assign cp_code = pll_config_register[rpc_pkg::BIT_MAN_CP]
    ? pll_config_register[rpc_pkg::CP_LSB +: 3] : auto_cp_reg;      // [R6]

  // Lock is gated off while disabled or calibrating
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      locked_reg   <= 1'b0;
      locked_q_reg <= 1'b0;
    end
    else
    begin
      locked_reg <= pll_en && !cal_busy && !lock_busy
        && PLL_LOCK_RAW && (lock_done || locked_reg);               // [R14]
      locked_q_reg <= locked_reg;
    end
  end

  // Outputs to the analog macro
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      PLL_SEL <= 1'b0;
      PLL_MULT <= 9'h000;
      CHARGE_PUMP_CURRENT <= 11'h000;
      VCO_CAL_ACTIVE <= 1'b0;
      DAC_CAL <= 1'b0;
    end
    else
    begin
      PLL_SEL <= pll_en;                                             // [R1]
      // Band limit sits in the VCO; logic only passes 2N on          [R2]
      PLL_MULT <= {div, 1'b0};                                       // [R5]
      CHARGE_PUMP_CURRENT <= 11'(({8'h00, cp_code} + 11'h001)
        * rpc_pkg::CP_STEP_UA);                                      // [R7]
      VCO_CAL_ACTIVE <= cal_busy;
      DAC_CAL <= dac_config_register[rpc_pkg::BIT_DAC_CAL];
    end
  end

  // Sticky events; set wins over clear
  assign irq_set = {cal_done, locked_q_reg && !locked_reg,
    locked_reg && !locked_q_reg};
  assign irq_clr = (wr && PREADY && PADDR == rpc_pkg::OFF_IRQ_CLR)
    ? PWDATA[rpc_pkg::IRQ_W-1:0] : '0;
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      irq_st_reg <= '0;
      IRQ <= 1'b0;
    end
    else
    begin
      irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_set;
      IRQ <= |(((irq_st_reg & ~irq_clr) | irq_set) & irq_en_reg);
    end
  end

  sel_follow_a: assert property (@(posedge CLK_SYS) // [R1]
    disable iff (SYS_RST) ##1 PLL_SEL == $past(pll_en))
    else $error("PLL select lags");
  // Output still holds its reset value on the first edge after release
  mult_even_a: assert property (@(posedge CLK_SYS) // [R5]
    disable iff (SYS_RST) ##1 $past(SYS_RST)
    || (!PLL_MULT[0] && PLL_MULT[8:1] == $past(div)))
    else $error("Multiplier not 2N");
  cp_manual_a: assert property (@(posedge CLK_SYS) // [R7]
    disable iff (SYS_RST) pll_config_register[rpc_pkg::BIT_MAN_CP]
    |=> CHARGE_PUMP_CURRENT == 11'(({8'h00,
    $past(pll_config_register[5:3])} + 11'h001) * 11'd125))
    else $error("Manual current wrong");
  cal_edge_a: assert property (@(posedge CLK_SYS) // [R13]
    disable iff (SYS_RST) cal_start |=> !cal_start)
    else $error("Cal restarted");
  lock_off_a: assert property (@(posedge CLK_SYS) // [R14]
    disable iff (SYS_RST) (!pll_en || cal_busy) |=> !locked_reg)
    else $error("Lock while off");
  lock_raw_a: assert property (@(posedge CLK_SYS) // [R11]
    disable iff (SYS_RST) locked_reg |-> $past(PLL_LOCK_RAW))
    else $error("Lock w/o PLL");
  auto_cp_a: assert property (@(posedge CLK_SYS) // [R6]
    disable iff (SYS_RST) (cal_start && div < 8'd16)
    |=> auto_cp_reg == 3'h0)
    else $error("Auto current band");
  ready_one_a: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
    PREADY |=> !PREADY) else $error("PREADY stuck");
  c_cal: cover property (@(posedge CLK_SYS) cal_done);
  c_lock: cover property (@(posedge CLK_SYS) $rose(locked_reg));
  c_irq: cover property (@(posedge CLK_SYS) $rose(IRQ));
  c_unlock: cover property (@(posedge CLK_SYS)
    irq_set[rpc_pkg::IRQ_UNLOCK]);
  c_auto: cover property (@(posedge CLK_SYS)
    cal_start && !pll_config_register[rpc_pkg::BIT_MAN_CP]);
endmodule : rpc_top

// *** design/rpc_pkg.sv ***
// Constants for the reference clock and PLL control block.
// Assumes one 100 MHz system clock and an APB master for software.
// Operation
// R1 - One PLL enable bit selects PLL output or direct reference as clock
// R2 - PLL path output is confined between 2.4 and 2.5 GHz
// R3 - Direct path: external source drives reference up to 3.5 GHz
// R4 - Software programs feedback divider 10 to 255, never below 10
// R5 - PLL multiplies reference by twice the divider value
// R6 - Charge pump current chosen by calibration unless manual bit set
// R7 - Manual code gives (code+1) times 125 uA; reset code 011
// R8 - Software should scale manual current with divider value
// R9 - Software sets calibration bit once reference stable, clears before next
// R10 - Software finishes VCO calibration before DAC calibration
// R11 - Read-only lock bit high while PLL locked to reference
// R12 - Software sets then clears DAC calibration bit after clock changes
// R13 - VCO calibration starts on rising edge of calibration bit only
// R14 - Lock bit reads zero while PLL disabled or calibration running
package rpc_pkg;
  localparam logic [7:0] OFF_GENERAL = 8'h00;
  localparam logic [7:0] OFF_PLL     = 8'h08;
  localparam logic [7:0] OFF_DAC     = 8'h0C;
  localparam logic [7:0] OFF_LOCK    = 8'h6C;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h70;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h74;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h78;
  localparam logic [7:0] OFF_MULT    = 8'h7C;
  localparam int BIT_VCO_CAL  = 24;
  localparam int BIT_DAC_CAL  = 24;
  localparam int BIT_LOCK     = 24;
  localparam int BIT_PLL_EN   = 2;
  localparam int BIT_MAN_CP   = 6;
  localparam int CP_LSB       = 3;
  localparam int DIV_LSB      = 8;
  localparam logic [7:0]  DIV_RESET = 8'h19;
  localparam logic [7:0]  DIV_MIN   = 8'h0A;
  localparam logic [2:0]  CP_RESET  = 3'h3;
  localparam logic [10:0] CP_STEP_UA = 11'h07D;
  localparam int VCO_CAL_US  = 20;
  localparam int CLK_MHZ     = 100;
  localparam int VCO_CAL_CYC = VCO_CAL_US * CLK_MHZ;
  localparam int LOCK_US     = 10;
  localparam int LOCK_CYC    = LOCK_US * CLK_MHZ;
  localparam int IRQ_W       = 3;
  localparam int IRQ_LOCK    = 0;
  localparam int IRQ_UNLOCK  = 1;
  localparam int IRQ_CALDONE = 2;
endpackage : rpc_pkg

// *** design/rpc_timer.sv ***
// Down counter that pulses once when a started interval expires.
// Assumes start is a one-cycle pulse; restart reloads the count.
`timescale 1ns/1ps
module rpc_timer #(
  parameter int CYC = 1000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  input  wire logic abort,
  output logic      busy,
  output logic      done
);
  logic [31:0] cnt_reg;

  always_ff @(posedge clk)
  begin
    if (rst || abort)
    begin
      cnt_reg <= 32'h0000_0000;
      busy    <= 1'b0;
      done    <= 1'b0;
    end
    else if (start)
    begin
      cnt_reg <= 32'(CYC - 1);
      busy    <= 1'b1;
      done    <= 1'b0;
    end
    else if (busy && cnt_reg == 32'h0000_0000)
    begin
      busy <= 1'b0;
      done <= 1'b1;
    end
    else
    begin
      cnt_reg <= busy ? cnt_reg - 32'h0000_0001 : cnt_reg;
      done    <= 1'b0;
    end
  end
endmodule : rpc_timer

// *** dv/rpc_ref_src.sv ***
// External reference source seen through the analog PLL lock level.
// Assumes pll_sel is the block's path select; drop models a lost reference.
`timescale 1ns/1ps
module rpc_ref_src (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pll_sel,
  input  wire logic drop,
  output logic      lock
);
  logic [1:0] settle_reg;
  // Reference runs only while not dropped; lock follows after settling
  always_ff @(posedge clk)
  begin
    if (rst || !pll_sel || drop)
    begin
      settle_reg <= 2'h0;
      lock       <= 1'b0;
    end
    else
    begin
      settle_reg <= settle_reg + ((settle_reg != 2'h3) ? 2'h1 : 2'h0);
      lock       <= (settle_reg == 2'h3);
    end
  end
endmodule : rpc_ref_src

// *** dv/tb_rpc_top.sv ***
// Self-checking bench for the reference clock and PLL control block.
// Assumes the APB answer comes after a wait state and short cal counts.
`timescale 1ns/1ps
module tb_rpc_top;
  logic        clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic        pready, pslverr, lock_raw, pll_sel, vco_act, dac_cal, irq;
  logic        drop = 0, er;
  logic [8:0]  mult;
  logic [10:0] cp_ua;
  int          n_fail = 0, samples_checked = 0, i;
  always #5 clk_sys = ~clk_sys;
  rpc_top #(.VCO_CAL_CYC(5), .LOCK_CYC(5)) dut (.CLK_SYS(clk_sys),
    .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PLL_LOCK_RAW(lock_raw), .PLL_SEL(pll_sel),
    .PLL_MULT(mult), .CHARGE_PUMP_CURRENT(cp_ua),
    .VCO_CAL_ACTIVE(vco_act), .DAC_CAL(dac_cal), .IRQ(irq));
  rpc_ref_src ref_src (.clk(clk_sys), .rst(sys_rst), .pll_sel(pll_sel),
    .drop(drop), .lock(lock_raw));
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Request held until the edge that samples pready high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    // No cycle count assumed; the watchdog ends a hung access
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    // Two idle edges so registered outputs show the write
    repeat (2) @(posedge clk_sys);
  endtask : apb
  task t_reset;
    apb(0, rpc_pkg::OFF_PLL, 0);
    chk(rd, 32'h0000_1918);
    apb(0, rpc_pkg::OFF_MULT, 0);
    chk(rd, 32'h0000_0032);
    chk(pll_sel, 1'b0);
    $display("t_reset done");
  endtask : t_reset
  task t_mult;
    logic [7:0] n;
    for (i = 0; i < 8; i++)
    begin
      // Top of recommended divider bands 0 to 6 (100 in band 7), manual code i
      case (i)
        0: n = 8'h0F;
        1: n = 8'h17;
        2: n = 8'h23;
        3: n = 8'h2B;
        4: n = 8'h37;
        5: n = 8'h3F;
        6: n = 8'h4F;
        default: n = 8'h64;
      endcase
      apb(1, rpc_pkg::OFF_PLL,
        {16'h0, n, 2'b01, 3'(i), 1'b1, 2'b00});
      chk(mult, {n, 1'b0});
      chk(cp_ua, 11'(i + 1) * 11'h07D);
      chk(pll_sel, 1'b1);
      apb(0, rpc_pkg::OFF_MULT, 0);
      chk(rd, {23'h0, n, 1'b0});
    end
    apb(1, rpc_pkg::OFF_PLL, 32'h0000_FF7C);
    apb(1, rpc_pkg::OFF_MULT, 32'h0000_0000);
    apb(0, rpc_pkg::OFF_MULT, 0);
    chk(rd, 32'h0000_01FE);
    $display("t_mult done");
  endtask : t_mult
  task t_cal;
    apb(1, rpc_pkg::OFF_PLL, 32'h0000_0F1C);
    apb(1, rpc_pkg::OFF_IRQ_EN, 32'h0000_0007);
    apb(1, rpc_pkg::OFF_GENERAL, 32'h0100_0000);
    for (i = 0; i < 20 && vco_act !== 1'b1; i++) @(posedge clk_sys);
    chk(vco_act, 1'b1);
    apb(0, rpc_pkg::OFF_LOCK, 0);
    chk(rd, 32'h0000_0000);
    for (i = 0; i < 40 && rd !== 32'h0100_0000; i++)
      apb(0, rpc_pkg::OFF_LOCK, 0);
    chk(rd, 32'h0100_0000);
    chk(cp_ua, 32'h0000_007D);
    apb(0, rpc_pkg::OFF_IRQ_ST, 0);
    chk(rd, 32'h0000_0005);
    chk(irq, 1'b1);
    apb(1, rpc_pkg::OFF_IRQ_EN, 32'h0000_0000);
    chk(irq, 1'b0);
    apb(1, rpc_pkg::OFF_IRQ_CLR, 32'h0000_0007);
    apb(0, rpc_pkg::OFF_IRQ_ST, 0);
    chk(rd, 32'h0000_0000);
    // Bit still high: rewriting it must not restart calibration
    apb(1, rpc_pkg::OFF_GENERAL, 32'h0100_0000);
    for (i = 0; i < 10; i++)
    begin
      @(posedge clk_sys);
      chk(vco_act, 1'b0);
    end
    drop <= 1;
    apb(0, rpc_pkg::OFF_LOCK, 0);
    for (i = 0; i < 40 && rd !== 32'h0000_0000; i++)
      apb(0, rpc_pkg::OFF_LOCK, 0);
    chk(rd, 32'h0000_0000);
    apb(0, rpc_pkg::OFF_IRQ_ST, 0);
    chk(rd, 32'h0000_0002);
    apb(1, rpc_pkg::OFF_GENERAL, 32'h0000_0000);
    apb(1, rpc_pkg::OFF_PLL, 32'h0000_1918);
    apb(0, rpc_pkg::OFF_LOCK, 0);
    chk(rd, 32'h0000_0000);
    chk(pll_sel, 1'b0);
    $display("t_cal done");
  endtask : t_cal
  task t_dac;
    apb(1, rpc_pkg::OFF_DAC, 32'h0100_0000);
    chk(dac_cal, 1'b1);
    apb(1, rpc_pkg::OFF_DAC, 32'h0000_0000);
    chk(dac_cal, 1'b0);
    apb(0, 8'hF0, 0);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    $display("t_dac done");
  endtask : t_dac
  initial
  begin
    #300000;
    n_fail++;
    summarize();
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 0;
    t_reset();
    t_mult();
    t_cal();
    t_dac();
    summarize();
  end
endmodule : tb_rpc_top
